// ---- design/iss_pkg.sv ----
package iss_pkg;

    // instruction classes seen by issue control
    typedef enum logic [4:0] {
        ISS_C_ISEL, ISS_C_FADD, ISS_C_FCBR, ISS_C_FSEL1, ISS_C_FSEL2, ISS_C_FDIV,
        ISS_C_FLD, ISS_C_FMUL, ISS_C_FSQRT, ISS_C_FST, ISS_C_FTOI, ISS_C_IADD,
        ISS_C_ICBR, ISS_C_ILD, ISS_C_ILOG, ISS_C_IMISC, ISS_C_IMUL, ISS_C_ISHF,
        ISS_C_IST, ISS_C_ITOF, ISS_C_JUMP, ISS_C_ADDR, ISS_C_MBAR, ISS_C_FCRD,
        ISS_C_IPRMV, ISS_C_NOP, ISS_C_CCNT, ISS_C_LOCK, ISS_C_UBR
    } iss_class_e;

    typedef logic [7:0] iss_pipe_t;

endpackage

// ---- design/iss_ready_mem.sv ----
`timescale 1ns/1ps
module iss_ready_mem #(
    parameter int DEPTH = 80,
    parameter int WIDTH = 19,
    parameter int AW = 7
) (
    input wire logic clk_in, // core clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic ce_in, // clock enable
    input wire logic wr_en_in, // write strobe
    input wire logic [AW-1:0] wr_addr_in, // write tag
    input wire logic [WIDTH-1:0] wr_data_in, // write entry
    input wire logic rd_en_in, // read strobe
    input wire logic [AW-1:0] rd_addr_in, // read tag
    output logic [WIDTH-1:0] rd_data_out // registered read entry
);

    logic [WIDTH-1:0] mem [DEPTH];

    // array has no reset; the owner keeps a valid bit per entry
    always_ff @(posedge clk_in) begin
        if (ce_in && wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // read before write: same-cycle write to the read tag is not seen
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else if (ce_in && rd_en_in) begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule // iss_ready_mem

// ---- design/iss_regs.svh ----
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH

// pipe mask bit positions
`define ISS_P_L0 0
`define ISS_P_L1 1
`define ISS_P_U0 2
`define ISS_P_U1 3
`define ISS_P_FA 4
`define ISS_P_FM 5
`define ISS_P_FLOAT_STORE_PIPE_ZERO 6
`define ISS_P_FLOAT_STORE_PIPE_ONE 7

// subcluster demand codes carried per instruction
`define ISS_SC_E 2'h0
`define ISS_SC_L 2'h1
`define ISS_SC_U 2'h2

// opcode groups that fix a class
`define ISS_OPC_ARITH 6'h10
`define ISS_OPC_SHIFT 6'h12

// result latencies in core cycles
`define ISS_LAT_INT1 6'h01
`define ISS_LAT_IMISC 6'h03
`define ISS_LAT_IMUL 6'h07
`define ISS_LAT_FP 6'h04
`define ISS_LAT_FP_STORE_EXTRA 6'h02
`define ISS_LAT_FDIV_S 6'h0c
`define ISS_LAT_FDIV_D 6'h0f
`define ISS_LAT_FSQRT_S 6'h12
`define ISS_LAT_FSQRT_D 6'h21
`define ISS_LAT_ILD_HIT 6'h03
`define ISS_LAT_ILD_MISS 6'h0d
`define ISS_LAT_FLD_HIT 6'h04
`define ISS_LAT_FLD_MISS 6'h0e
`define ISS_LAT_FTOI 6'h03
`define ISS_LAT_ITOF 6'h04
`define ISS_LAT_JUMP 6'h03
`define ISS_LAT_IPR_FAST 6'h01
`define ISS_LAT_IPR_SLOW 6'h03
`define ISS_XC_DELAY 6'h01

// unit reuse intervals in core cycles
`define ISS_REUSE_DIV_S 6'h09
`define ISS_REUSE_DIV_D 6'h0c
`define ISS_REUSE_SQRT_S 6'h0f
`define ISS_REUSE_SQRT_D 6'h1e

// queue sizes and issue widths
`define ISS_IQ_DEPTH 20
`define ISS_FQ_DEPTH 15
`define ISS_IQ_WIDTH 4
`define ISS_FQ_WIDTH 2

`endif

// ---- design/iss_slot_sched.sv ----
// Function
// - float operates, divide, root, branch, select halves go only to float add pipe
// - float multiply and float control read go only to float multiply pipe
// - integer/float loads, integer stores, int-to-float moves use lower pipes only
// - float stores and float-to-int moves use float store pipes or lower pipes
// - arithmetic opcode group minus byte compare, logic, address, select: any int pipe
// - shift opcode group and integer branches go only to the upper pipes
// - integer misc only to upper pipe zero, integer multiply only to upper pipe one
// - all jump class instructions go only to lower pipe zero
// - register moves to lower zero or one by target; barrier, counter, lock to lower one
// - no-operation class gets no pipe at all
// - either-cluster integer instructions are bound per fetch line at map time
// - slot position is taken from program counter bits three and two
// - upper/lower/either pattern maps through a fixed table; fixed slots keep cluster
// - issue waits for operands and units; latency fixed except load misses
// - loads ready after 3 or 4 on hit, 13 or 14 plus loop delay on miss
// - float add, multiply, select second half: 4 cycles, 6 to store consumers
// - divide ready 12 or 15, divider reusable after 9 or 12
// - root ready 18 or 33, unit reusable after 15 or 30
// - simple int 1, misc 3, multiply 7, plus one across clusters
// - select first halves feed second halves after 4 (float) or 1 (integer)
// - register reads ready after 1 or 3, register writes give no result
// - stores, branches, barriers and no-ops produce no register value
// - integer queue 20 entries issuing 4, float queue 15 entries issuing 2
// - issued entry stays one cycle without service, deleted two cycles after issue
`timescale 1ns/1ps
`include "iss_regs.svh"
module iss_slot_sched
    import iss_pkg::*;
#(
    parameter int NREG = 80,
    parameter int TAGW = 7,
    parameter int TW = 16,
    parameter int IQ_N = `ISS_IQ_DEPTH,
    parameter int FQ_N = `ISS_FQ_DEPTH,
    parameter int IQ_W = `ISS_IQ_WIDTH,
    parameter int FQ_W = `ISS_FQ_WIDTH,
    parameter logic [5:0] BC_EXTRA = 6'h0
) (
    input wire logic core_clk_in, // core clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic ce_in, // clock enable, freezes all state when low
    input wire logic cls_valid_in, // classify request
    input wire iss_class_e cls_code_in, // class from decode
    input wire logic [5:0] cls_opc_in, // major opcode
    input wire logic cls_bytecmp_in, // byte compare instruction
    input wire logic cls_ipr_lower1_in, // register move targets lower pipe one
    output iss_pipe_t pipe_mask_out, // permitted pipes
    output logic pipe_valid_out, // mask valid
    input wire logic slot_valid_in, // fetch line present
    input wire logic [7:0] slot_code_in, // demand code per instruction
    input wire logic [7:0] slot_pc_in, // pc bits 3:2 per instruction
    output logic [3:0] slot_upper_out, // per position, 1 = upper
    output logic slot_done_out, // slotting valid
    input wire logic prd_issue_in, // producer issues
    input wire iss_class_e prd_class_in, // producer class
    input wire logic [TAGW-1:0] prd_dest_in, // destination tag
    input wire logic prd_double_in, // double precision
    input wire logic prd_miss_in, // load missed data cache
    input wire logic prd_ipr_slow_in, // register read from fetch/memory unit
    input wire logic prd_ipr_write_in, // register move is a write
    input wire logic prd_upper_in, // producer in upper cluster
    output logic prd_refused_out, // issue refused, unit busy
    input wire logic cns_req_in, // consumer readiness query
    input wire logic [TAGW-1:0] cns_src_in, // source tag
    input wire logic cns_upper_in, // consumer in upper cluster
    input wire logic cns_fstore_in, // consumer is float store or float-to-int
    output logic cns_done_out, // query answered
    output logic cns_ready_out, // operand ready this cycle
    output logic div_free_out, // divider may be used
    output logic sqrt_free_out, // root unit may be used
    input wire logic [IQ_N-1:0] iq_issue_in, // integer queue entries issued
    input wire logic [FQ_N-1:0] fq_issue_in, // float queue entries issued
    output logic [IQ_N-1:0] iq_hold_out, // integer entries held, no service
    output logic [IQ_N-1:0] iq_delete_out, // integer entries to delete
    output logic [FQ_N-1:0] fq_hold_out, // float entries held, no service
    output logic [FQ_N-1:0] fq_delete_out, // float entries to delete
    output logic iss_over_out // issue width exceeded
);

    ////////////////////////////////////////////////////////////////////////////
    // types, table, helpers

    typedef struct packed {
        logic [TW-1:0] rtime;
        logic xc;
        logic fs;
        logic up;
    } iss_entry_s;

    typedef struct packed {
        iss_pipe_t pmask;
        logic pval;
        logic [3:0] supper;
        logic sdone;
        logic [TW-1:0] now;
        logic [5:0] divc;
        logic [5:0] sqrc;
        logic dfree;
        logic sfree;
        logic refused;
        logic [NREG-1:0] vld;
        logic c1_req;
        logic c1_vld;
        logic c1_upper;
        logic c1_fst;
        logic cdone;
        logic crdy;
        logic [IQ_N-1:0] iqh;
        logic [IQ_N-1:0] iqd;
        logic [FQ_N-1:0] fqh;
        logic [FQ_N-1:0] fqd;
        logic over;
    } iss_state_s;

    // index = pos3*27 + pos2*9 + pos1*3 + pos0, with E=0 L=1 U=2
    localparam logic [3:0] SLOT_TBL [81] = '{
        4'ha, 4'ha, 4'h9, 4'h9, 4'hc, 4'h9, 4'ha, 4'ha, 4'h3,
        4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h9, 4'ha, 4'ha, 4'h3,
        4'h5, 4'h6, 4'h5, 4'h5, 4'hc, 4'h5, 4'h6, 4'h6, 4'h7,
        4'h5, 4'h6, 4'h5, 4'h5, 4'h4, 4'h5, 4'h6, 4'h6, 4'h3,
        4'h3, 4'h2, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h2, 4'h3,
        4'h5, 4'h6, 4'h5, 4'h5, 4'h4, 4'h5, 4'h6, 4'h6, 4'h7,
        4'ha, 4'ha, 4'h9, 4'h9, 4'hc, 4'h9, 4'ha, 4'ha, 4'hb,
        4'ha, 4'ha, 4'h9, 4'h9, 4'h8, 4'h9, 4'ha, 4'ha, 4'hb,
        4'hc, 4'hc, 4'hd, 4'hc, 4'hc, 4'hd, 4'he, 4'he, 4'hf
    };

    // opcode group overrides the decoded class
    function automatic iss_class_e reclass(iss_class_e c, logic [5:0] opc, logic bc);
        if (bc) return ISS_C_ILOG;
        if (opc == `ISS_OPC_ARITH) return ISS_C_IADD;
        if (opc == `ISS_OPC_SHIFT) return ISS_C_ISHF;
        return c;
    endfunction

    function automatic iss_pipe_t pipes(iss_class_e c, logic l1);
        iss_pipe_t m;
        m = '0;
        case (c)
            ISS_C_ISEL, ISS_C_IADD, ISS_C_ILOG, ISS_C_ADDR: begin
                m[`ISS_P_L0] = 1'b1;
                m[`ISS_P_L1] = 1'b1;
                m[`ISS_P_U0] = 1'b1;
                m[`ISS_P_U1] = 1'b1;
            end
            ISS_C_FADD, ISS_C_FCBR, ISS_C_FSEL1, ISS_C_FSEL2, ISS_C_FDIV, ISS_C_FSQRT: begin
                m[`ISS_P_FA] = 1'b1;
            end
            ISS_C_FMUL, ISS_C_FCRD: m[`ISS_P_FM] = 1'b1;
            ISS_C_FLD, ISS_C_ILD, ISS_C_IST, ISS_C_ITOF: begin
                m[`ISS_P_L0] = 1'b1;
                m[`ISS_P_L1] = 1'b1;
            end
            ISS_C_FST, ISS_C_FTOI: begin
                m[`ISS_P_FLOAT_STORE_PIPE_ZERO] = 1'b1;
                m[`ISS_P_FLOAT_STORE_PIPE_ONE] = 1'b1;
                m[`ISS_P_L0] = 1'b1;
                m[`ISS_P_L1] = 1'b1;
            end
            ISS_C_ISHF, ISS_C_ICBR: begin
                m[`ISS_P_U0] = 1'b1;
                m[`ISS_P_U1] = 1'b1;
            end
            ISS_C_IMISC: m[`ISS_P_U0] = 1'b1;
            ISS_C_IMUL: m[`ISS_P_U1] = 1'b1;
            ISS_C_JUMP, ISS_C_UBR: m[`ISS_P_L0] = 1'b1;
            ISS_C_IPRMV: m[l1 ? `ISS_P_L1 : `ISS_P_L0] = 1'b1;
            ISS_C_MBAR, ISS_C_CCNT, ISS_C_LOCK: m[`ISS_P_L1] = 1'b1;
            default: m = '0;
        endcase
        return m;
    endfunction

    // fixed class latency; only load misses vary with the board loop
    function automatic logic [5:0] lat_of(iss_class_e c, logic dbl, logic miss, logic slow);
        case (c)
            ISS_C_ISEL, ISS_C_IADD, ISS_C_ILOG, ISS_C_ISHF, ISS_C_ADDR, ISS_C_CCNT,
            ISS_C_LOCK: return `ISS_LAT_INT1;
            ISS_C_IMISC: return `ISS_LAT_IMISC;
            ISS_C_IMUL: return `ISS_LAT_IMUL;
            ISS_C_FADD, ISS_C_FMUL, ISS_C_FSEL1, ISS_C_FSEL2,
            ISS_C_FCRD: return `ISS_LAT_FP;
            ISS_C_FDIV: return dbl ? `ISS_LAT_FDIV_D : `ISS_LAT_FDIV_S;
            ISS_C_FSQRT: return dbl ? `ISS_LAT_FSQRT_D : `ISS_LAT_FSQRT_S;
            ISS_C_ILD: return miss ? 6'(`ISS_LAT_ILD_MISS + BC_EXTRA) : `ISS_LAT_ILD_HIT;
            ISS_C_FLD: return miss ? 6'(`ISS_LAT_FLD_MISS + BC_EXTRA) : `ISS_LAT_FLD_HIT;
            ISS_C_FTOI: return `ISS_LAT_FTOI;
            ISS_C_ITOF: return `ISS_LAT_ITOF;
            ISS_C_JUMP: return `ISS_LAT_JUMP;
            ISS_C_IPRMV: return slow ? `ISS_LAT_IPR_SLOW : `ISS_LAT_IPR_FAST;
            default: return 6'h0;
        endcase
    endfunction

    function automatic logic has_val(iss_class_e c, logic ipr_wr);
        case (c)
            ISS_C_FCBR, ISS_C_FST, ISS_C_ICBR, ISS_C_IST, ISS_C_MBAR, ISS_C_NOP,
            ISS_C_UBR: return 1'b0;
            ISS_C_IPRMV: return !ipr_wr;
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic xc_of(iss_class_e c);
        return c inside {ISS_C_ISEL, ISS_C_IADD, ISS_C_ILOG, ISS_C_ISHF, ISS_C_IMISC,
                         ISS_C_IMUL, ISS_C_ADDR, ISS_C_CCNT};
    endfunction

    function automatic logic fs_of(iss_class_e c);
        return c inside {ISS_C_FADD, ISS_C_FMUL, ISS_C_FSEL2};
    endfunction

    // place each instruction at the position its pc names
    function automatic logic [6:0] slot_idx(logic [7:0] pc, logic [7:0] cd);
        logic [1:0] p [4];
        for (int i = 0; i < 4; i++) begin
            p[i] = `ISS_SC_E;
        end
        for (int i = 0; i < 4; i++) begin
            p[pc[2*i +: 2]] = (cd[2*i +: 2] == `ISS_SC_L || cd[2*i +: 2] == `ISS_SC_U)
                              ? cd[2*i +: 2] : `ISS_SC_E;
        end
        return 7'(7'(p[3]) * 7'h1b + 7'(p[2]) * 7'h09 + 7'(p[1]) * 7'h03 + 7'(p[0]));
    endfunction

    function automatic int unsigned pop(logic [31:0] v);
        int unsigned n;
        n = 0;
        for (int i = 0; i < 32; i++) begin
            n = n + 32'(v[i]);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    iss_state_s st_ff;
    iss_state_s nxt_st;
    iss_class_e eff_cls;
    logic div_req;
    logic sqrt_req;
    logic prd_take;
    logic wr_en;
    iss_entry_s wr_ent;
    iss_entry_s rd_ent;
    logic [TW-1:0] ready_eff;
    logic [TW-1:0] cns_diff;

    assign eff_cls = reclass(cls_code_in, cls_opc_in, cls_bytecmp_in);

    // a busy divider or root unit refuses the issue outright
    assign div_req = prd_issue_in && prd_class_in == ISS_C_FDIV;
    assign sqrt_req = prd_issue_in && prd_class_in == ISS_C_FSQRT;
    assign prd_take = prd_issue_in && !(div_req && !st_ff.dfree)
                      && !(sqrt_req && !st_ff.sfree);
    assign wr_en = ce_in && prd_take && has_val(prd_class_in, prd_ipr_write_in);

    // ready cycle = issue cycle + latency
    assign wr_ent.rtime = TW'(st_ff.now + TW'(lat_of(prd_class_in, prd_double_in,
                                prd_miss_in, prd_ipr_slow_in)));
    assign wr_ent.xc = xc_of(prd_class_in);
    assign wr_ent.fs = fs_of(prd_class_in);
    assign wr_ent.up = prd_upper_in;

    // cross-cluster and store-consumer adders applied at query time
    assign ready_eff = TW'(rd_ent.rtime
        + ((rd_ent.xc && rd_ent.up != st_ff.c1_upper) ? TW'(`ISS_XC_DELAY) : TW'(0))
        + ((rd_ent.fs && st_ff.c1_fst) ? TW'(`ISS_LAT_FP_STORE_EXTRA) : TW'(0)));
    // wrap-safe compare against the cycle the answer is shown
    assign cns_diff = TW'(st_ff.now + 1'b1 - ready_eff);

    iss_ready_mem #(.DEPTH(NREG), .WIDTH(TW + 3), .AW(TAGW)) u_ready_mem (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_en_in(wr_en),
        .wr_addr_in(prd_dest_in),
        .wr_data_in(wr_ent),
        .rd_en_in(cns_req_in),
        .rd_addr_in(cns_src_in),
        .rd_data_out(rd_ent)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        if (ce_in) begin
            nxt_st.now = TW'(st_ff.now + 1'b1);
            nxt_st.pval = cls_valid_in;
            nxt_st.pmask = cls_valid_in ? pipes(eff_cls, cls_ipr_lower1_in) : '0;
            // binding of either-cluster slots per line
            nxt_st.sdone = slot_valid_in;
            if (slot_valid_in) begin
                nxt_st.supper = SLOT_TBL[slot_idx(slot_pc_in, slot_code_in)];
            end
            // reuse counters count down to free
            if (div_req && prd_take) begin
                nxt_st.divc = prd_double_in ? `ISS_REUSE_DIV_D - 6'h1
                                            : `ISS_REUSE_DIV_S - 6'h1;
            end else if (st_ff.divc != 6'h0) begin
                nxt_st.divc = st_ff.divc - 6'h1;
            end
            if (sqrt_req && prd_take) begin
                nxt_st.sqrc = prd_double_in ? `ISS_REUSE_SQRT_D - 6'h1
                                            : `ISS_REUSE_SQRT_S - 6'h1;
            end else if (st_ff.sqrc != 6'h0) begin
                nxt_st.sqrc = st_ff.sqrc - 6'h1;
            end
            nxt_st.dfree = (nxt_st.divc == 6'h0);
            nxt_st.sfree = (nxt_st.sqrc == 6'h0);
            nxt_st.refused = prd_issue_in && !prd_take;
            if (wr_en) begin
                nxt_st.vld[prd_dest_in] = 1'b1;
            end
            // query stage one: capture request, memory reads alongside
            nxt_st.c1_req = cns_req_in;
            nxt_st.c1_vld = st_ff.vld[cns_src_in];
            nxt_st.c1_upper = cns_upper_in;
            nxt_st.c1_fst = cns_fstore_in;
            nxt_st.cdone = st_ff.c1_req;
            nxt_st.crdy = st_ff.c1_req && (!st_ff.c1_vld || !cns_diff[TW-1]);
            // issued entries idle one cycle, then delete
            nxt_st.iqh = iq_issue_in;
            nxt_st.iqd = st_ff.iqh;
            nxt_st.fqh = fq_issue_in;
            nxt_st.fqd = st_ff.fqh;
            nxt_st.over = (pop(32'(iq_issue_in)) > IQ_W)
                          || (pop(32'(fq_issue_in)) > FQ_W);
        end
    end

    // single state register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.dfree <= 1'b1;
            st_ff.sfree <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pipe_mask_out = st_ff.pmask;
    assign pipe_valid_out = st_ff.pval;
    assign slot_upper_out = st_ff.supper;
    assign slot_done_out = st_ff.sdone;
    assign prd_refused_out = st_ff.refused;
    assign cns_done_out = st_ff.cdone;
    assign cns_ready_out = st_ff.crdy;
    assign div_free_out = st_ff.dfree;
    assign sqrt_free_out = st_ff.sfree;
    assign iq_hold_out = st_ff.iqh;
    assign iq_delete_out = st_ff.iqd;
    assign fq_hold_out = st_ff.fqh;
    assign fq_delete_out = st_ff.fqd;
    assign iss_over_out = st_ff.over;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking dcb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_div_take;
        ce_in && div_req && prd_take && !prd_double_in;
    endsequence

    sequence s_sqrt_take;
        ce_in && sqrt_req && prd_take && !prd_double_in;
    endsequence

    sequence s_fld_hit;
        ce_in && prd_take && prd_class_in == ISS_C_FLD && !prd_miss_in;
    endsequence

    a_fmul_pipe_only: assert property (
        ce_in && cls_valid_in && eff_cls == ISS_C_FMUL |=> pipe_mask_out == 8'h20)
        else $error("float multiply not confined to multiply pipe");
    a_nop_no_pipe: assert property (
        ce_in && cls_valid_in && eff_cls == ISS_C_NOP |=> pipe_valid_out && pipe_mask_out == 8'h0)
        else $error("no-op class given a pipe");
    a_jump_lower_zero: assert property (
        ce_in && cls_valid_in && eff_cls == ISS_C_JUMP |=> pipe_mask_out == 8'h01)
        else $error("jump class not on lower pipe zero");
    a_load_lower_pair: assert property (
        ce_in && cls_valid_in && eff_cls == ISS_C_ILD |=> pipe_mask_out == 8'h03)
        else $error("integer load left the lower pipes");
    a_slot_eell_line: assert property (
        ce_in && slot_valid_in && slot_pc_in == 8'he4 && slot_code_in == 8'h05
        |=> slot_done_out && slot_upper_out == 4'hc)
        else $error("pattern EELL not slotted UULL");
    a_div_reuse_held: assert property (
        s_div_take ##1 ce_in [*7] |=> !div_free_out)
        else $error("divider freed before reuse interval");
    a_div_reuse_free: assert property (
        s_div_take ##1 ce_in [*8] |=> div_free_out)
        else $error("divider not freed after reuse interval");
    a_sqrt_reuse_free: assert property (
        s_sqrt_take ##1 ce_in [*7] ##1 ce_in [*7] |=> sqrt_free_out)
        else $error("root unit not freed after reuse interval");
    a_div_busy_refuse: assert property (
        ce_in && div_req && !div_free_out |=> prd_refused_out)
        else $error("divide accepted while unit busy");
    a_fld_not_early: assert property (
        s_fld_hit ##1 (ce_in && cns_req_in && cns_src_in == $past(prd_dest_in)
        && !prd_issue_in) ##1 ce_in |=> cns_done_out && !cns_ready_out)
        else $error("float load result shown ready before four cycles");
    a_queue_delete: assert property (
        ce_in && iq_issue_in[0] ##1 ce_in |-> iq_hold_out[0] ##1 iq_delete_out[0])
        else $error("issued entry not held then deleted");

endmodule // iss_slot_sched

// ---- dv/iss_queue_model.sv ----
`timescale 1ns/1ps
module iss_queue_model (
    input wire logic core_clk_in, // core clock
    input wire logic run_in, // emit traffic
    output logic [19:0] iq_issue_out = 20'h0, // integer entries issued
    output logic [14:0] fq_issue_out = 15'h0 // float entries issued
);
    int seed = 44545;
    // anded draws: each bit set one time in four, so widths often exceed the limits and set the overflow flag
    always @(posedge core_clk_in) begin
        #1;
        iq_issue_out = run_in ? 20'($random(seed)) & 20'($random(seed)) : 20'h0;
        fq_issue_out = run_in ? 15'($random(seed)) & 15'($random(seed)) : 15'h0;
    end
endmodule // iss_queue_model

// ---- dv/test_issue_slotting_scoreboard.sv ----
`timescale 1ns/1ps
module test_issue_slotting_scoreboard;
    import iss_pkg::*;
    logic core_clk_in = 0, rst_n_in = 0, ce_in = 1, cls_valid_in = 0, cls_bytecmp_in = 0;
    logic cls_ipr_lower1_in = 0, slot_valid_in = 0, prd_issue_in = 0, prd_double_in = 0;
    logic prd_miss_in = 0, prd_ipr_slow_in = 0, prd_ipr_write_in = 0, prd_upper_in = 0;
    logic cns_req_in = 0, cns_upper_in = 0, cns_fstore_in = 0, run = 0;
    logic pipe_valid_out, slot_done_out, prd_refused_out, cns_done_out, cns_ready_out;
    logic div_free_out, sqrt_free_out, iss_over_out;
    iss_class_e cls_code_in = ISS_C_NOP, prd_class_in = ISS_C_NOP;
    logic [5:0] cls_opc_in = 6'h0;
    logic [7:0] slot_code_in = 8'h0, slot_pc_in = 8'he4;
    logic [6:0] prd_dest_in = 7'h0, cns_src_in = 7'h0;
    iss_pipe_t pipe_mask_out;
    logic [3:0] slot_upper_out;
    logic [19:0] iq_issue_in, iq_hold_out, iq_delete_out, h1i, h2i;
    logic [14:0] fq_issue_in, fq_hold_out, fq_delete_out, h1f, h2f;
    logic [7:0] sc [5] = '{8'h05, 8'h00, 8'h55, 8'haa, 8'h50};
    logic [7:0] sp [5] = '{8'he4, 8'he4, 8'he4, 8'he4, 8'h1b};
    logic [3:0] su [5] = '{4'hc, 4'ha, 4'h0, 4'hf, 4'hc};
    iss_class_e lc [5] = '{ISS_C_ILD, ISS_C_FLD, ISS_C_IMUL, ISS_C_IMISC, ISS_C_IMISC};
    logic lu [5] = '{0, 0, 0, 0, 1};
    logic lr [5] = '{1, 0, 0, 1, 0};
    int n_fail = 0, check_count = 0, seed = 44545;

    initial forever #2.5 core_clk_in = ~core_clk_in;
    iss_queue_model partner (.core_clk_in, .run_in(run), .iq_issue_out(iq_issue_in),
        .fq_issue_out(fq_issue_in));
    iss_slot_sched dut (.core_clk_in, .rst_n_in, .ce_in, .cls_valid_in, .cls_code_in,
        .cls_opc_in, .cls_bytecmp_in, .cls_ipr_lower1_in, .pipe_mask_out, .pipe_valid_out,
        .slot_valid_in, .slot_code_in, .slot_pc_in, .slot_upper_out, .slot_done_out,
        .prd_issue_in, .prd_class_in, .prd_dest_in, .prd_double_in, .prd_miss_in,
        .prd_ipr_slow_in, .prd_ipr_write_in, .prd_upper_in, .prd_refused_out, .cns_req_in,
        .cns_src_in, .cns_upper_in, .cns_fstore_in, .cns_done_out, .cns_ready_out,
        .div_free_out, .sqrt_free_out, .iq_issue_in, .fq_issue_in, .iq_hold_out,
        .iq_delete_out, .fq_hold_out, .fq_delete_out, .iss_over_out);
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [19:0] seen, input logic [19:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task tick;
        @(posedge core_clk_in);
        #1;
    endtask
    // pipes each class may use
    function iss_pipe_t pipes(iss_class_e c, logic l1);
        case (c)
            ISS_C_FADD, ISS_C_FCBR, ISS_C_FSEL1, ISS_C_FSEL2, ISS_C_FDIV, ISS_C_FSQRT: return 8'h10;
            ISS_C_FMUL, ISS_C_FCRD: return 8'h20;
            ISS_C_ILD, ISS_C_FLD, ISS_C_IST, ISS_C_ITOF: return 8'h03;
            ISS_C_FST, ISS_C_FTOI: return 8'hc3;
            ISS_C_IADD, ISS_C_ILOG, ISS_C_ADDR, ISS_C_ISEL: return 8'h0f;
            ISS_C_ISHF, ISS_C_ICBR: return 8'h0c;
            ISS_C_IMISC: return 8'h04;
            ISS_C_IMUL: return 8'h08;
            ISS_C_JUMP, ISS_C_UBR: return 8'h01;
            ISS_C_IPRMV: return l1 ? 8'h02 : 8'h01;
            ISS_C_MBAR, ISS_C_CCNT, ISS_C_LOCK: return 8'h02;
            default: return 8'h00;
        endcase
    endfunction
    // queue history, sampled on the same edge as the block
    always @(posedge core_clk_in) begin
        h2i <= h1i;
        h1i <= iq_issue_in;
        h2f <= h1f;
        h1f <= fq_issue_in;
    end
    // hang guard: the whole run needs well under a microsecond
    initial begin
        #5000;
        n_fail++;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk_in);
        #1 rst_n_in = 1;
        check(div_free_out, 1, "div free");
        cls_valid_in = 1;
        for (int c = 0; c <= 28; c++) begin
            cls_code_in = iss_class_e'(c);
            cls_ipr_lower1_in = 1'($random(seed));
            tick;
            check({pipe_valid_out, pipe_mask_out}, {1'b1, pipes(cls_code_in, cls_ipr_lower1_in)}, "pipes");
        end
        cls_opc_in = 6'h10;
        tick;
        check(pipe_mask_out, 8'h0f, "arith group");
        cls_opc_in = 6'h12;
        tick;
        check(pipe_mask_out, 8'h0c, "shift group");
        cls_bytecmp_in = 1;
        tick;
        check(pipe_mask_out, 8'h0f, "byte compare");
        cls_valid_in = 0;
        tick;
        check({pipe_valid_out, pipe_mask_out}, 9'h0, "idle");
        // fetch-line patterns, last one with positions reversed
        slot_valid_in = 1;
        foreach (sc[i]) begin
            slot_code_in = sc[i];
            slot_pc_in = sp[i];
            tick;
            check({slot_done_out, slot_upper_out}, {1'b1, su[i]}, "slot");
        end
        slot_valid_in = 0;
        // producer then query one cycle later, answer two after that
        foreach (lc[i]) begin
            prd_issue_in = 1;
            prd_class_in = lc[i];
            prd_upper_in = lu[i];
            prd_dest_in = 7'(i + 1);
            tick;
            prd_issue_in = 0;
            cns_req_in = 1;
            cns_src_in = 7'(i + 1);
            tick;
            cns_req_in = 0;
            tick;
            check({cns_done_out, cns_ready_out}, {1'b1, lr[i]}, "ready");
        end
        // single divide, then a second one that the busy divider must refuse
        prd_class_in = ISS_C_FDIV;
        prd_issue_in = 1;
        tick;
        check(div_free_out, 0, "div busy");
        tick;
        prd_issue_in = 0;
        check(prd_refused_out, 1, "refused");
        repeat (5) tick;
        check({sqrt_free_out, div_free_out}, 2'h2, "div still busy");
        repeat (3) tick;
        check(div_free_out, 1, "div reusable");
        prd_class_in = ISS_C_FSQRT;
        prd_issue_in = 1;
        tick;
        prd_issue_in = 0;
        repeat (13) tick;
        check(sqrt_free_out, 0, "root busy");
        tick;
        check(sqrt_free_out, 1, "root reusable");
        run = 1;
        repeat (30) begin
            tick;
            #1;
            check(iq_hold_out, h1i, "int hold");
            check(iq_delete_out, h2i, "int delete");
            check({fq_hold_out, fq_delete_out}, {h1f, h2f}, "float hold delete");
            check(iss_over_out, $countones(h1i) > 4 || $countones(h1f) > 2, "over");
        end
        stop_test;
    end
endmodule // test_issue_slotting_scoreboard
